// >>> acir_top.sv
// module: conversion done flags, interrupt enables and intermediate snapshot
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module acir_top
    import acir_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire acir_seq_evt_t seq_evt,
    output logic               conv_irq,
    output logic               converter_enable,
    output logic               store_on_abort,
    output logic               halt_in_wait
);

    // one-hot decode of a flag select code into a flag vector
    function automatic logic [15:0] slot_decode(input logic [3:0] code);
        logic [15:0] v;
        v = 16'h0000;
        if (code != 4'h0) begin
            v[code] = 1'b1;
        end
        return v;
    endfunction

    // byte lane mask for the low 16 data bits
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, answer on the second cycle
    acir_bus_st_t bus_st_ff;
    acir_bus_st_t nxt_bus_st;
    logic [31:0]  rdata_ff;
    logic [31:0]  nxt_rdata;
    logic         wait_ff;
    logic         nxt_wait;
    logic         wr_take;

    logic [4:0]   ctrl_ff;
    logic [15:0]  flags_ff;
    logic [15:0]  en_ff;
    logic         abort_done_ff;
    logic         overrun_ff;
    logic         snap_list_bank_ff;
    logic         snap_result_bank_ff;
    logic [5:0]   snap_result_index_ff;
    logic [5:0]   last_index_ff;
    logic         irq_ff;

    assign wr_take = avs_write && (bus_st_ff == BUS_ACK);

    always_comb begin
        nxt_bus_st = bus_st_ff;
        nxt_rdata  = rdata_ff;
        nxt_wait   = 1'b1;
        case (bus_st_ff)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_bus_st = BUS_ACK;
                    nxt_wait   = 1'b0;
                    nxt_rdata  = RDATA_RST;
                    if (avs_read) begin
                        case (avs_address)
                            IDX_CTRL:   nxt_rdata[4:0]  = ctrl_ff;
                            IDX_STATUS: begin
                                nxt_rdata[STAT_ABORT_DONE] = abort_done_ff;
                                nxt_rdata[STAT_OVERRUN]    = overrun_ff;
                            end
                            IDX_FLAGS:  nxt_rdata[15:0] = flags_ff;
                            IDX_ENABLE: nxt_rdata[15:0] = en_ff;
                            IDX_SNAP: begin
                                nxt_rdata[SNAP_LIST_BANK]   = snap_list_bank_ff;
                                nxt_rdata[SNAP_RESULT_BANK] =
                                    snap_result_bank_ff;
                                nxt_rdata[5:0] = snap_result_index_ff;
                            end
                            default:    nxt_rdata = RDATA_RST;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                nxt_bus_st = BUS_IDLE;
            end
            default: begin
                nxt_bus_st = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bus_st_ff <= BUS_IDLE;
            rdata_ff  <= RDATA_RST;
            wait_ff   <= 1'b1;
        end else begin
            bus_st_ff <= nxt_bus_st;
            rdata_ff  <= nxt_rdata;
            wait_ff   <= nxt_wait;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;

    //////////////////////////////////////////////////////////////////////////
    // control and enable registers
    logic [4:0]  nxt_ctrl;
    logic [15:0] nxt_en;
    logic [15:0] wmask;

    assign wmask = lane_mask(avs_byteenable);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_en   = en_ff;
        if (wr_take && avs_address == IDX_CTRL && avs_byteenable[0]) begin
            nxt_ctrl = avs_writedata[4:0];
        end
        if (wr_take && avs_address == IDX_ENABLE) begin
            nxt_en = (en_ff & ~wmask) | (avs_writedata[15:0] & wmask);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RST;
            en_ff   <= ENABLE_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            en_ff   <= nxt_en;
        end
    end

    assign converter_enable = ctrl_ff[CTRL_CONV_EN];
    assign store_on_abort   = ctrl_ff[CTRL_STORE_AB];
    assign halt_in_wait     = ctrl_ff[CTRL_HALT_WAIT];

    //////////////////////////////////////////////////////////////////////////
    // done flags, status flags and snapshot
    logic        blank;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic        list_end_cmd;
    logic        hw_abort;
    logic        ovr_evt;
    logic [15:0] nxt_flags;
    logic        nxt_abort_done;
    logic        nxt_overrun;
    logic        nxt_snap_list_bank;
    logic        nxt_snap_result_bank;
    logic [5:0]  nxt_snap_result_index;
    logic [5:0]  nxt_last_index;
    logic        nxt_irq;

    assign blank = !ctrl_ff[CTRL_CONV_EN]
                || ctrl_ff[CTRL_SOFT_RST];
    assign list_end_cmd = seq_evt.command_type_code[1];
    assign hw_abort = seq_evt.stop_abort
                   || (seq_evt.wait_abort && ctrl_ff[CTRL_HALT_WAIT]);

    always_comb begin
        set_vec = 16'h0000;
        if (seq_evt.store_done) begin
            set_vec = slot_decode(
                seq_evt.flag_select_code);
            set_vec[LIST_END_BIT] = list_end_cmd;
        end
        clr_vec = 16'h0000;
        if (wr_take && avs_address == IDX_FLAGS) begin
            clr_vec = avs_writedata[15:0] & wmask;
        end
        if (ctrl_ff[CTRL_DBL_BUF]) begin
            ovr_evt = |(set_vec & flags_ff);
        end else begin
            ovr_evt = seq_evt.store_done && seq_evt.first_of_list
                   && (|flags_ff[15:1]);
        end
    end

    always_comb begin
        nxt_flags             = (flags_ff & ~clr_vec) | set_vec;
        nxt_abort_done        = abort_done_ff;
        nxt_overrun           = overrun_ff | ovr_evt;
        nxt_snap_list_bank    = snap_list_bank_ff;
        nxt_snap_result_bank  = snap_result_bank_ff;
        nxt_snap_result_index = snap_result_index_ff;
        nxt_last_index        = last_index_ff;
        if (wr_take && avs_address == IDX_STATUS && avs_byteenable[0]) begin
            if (avs_writedata[STAT_ABORT_DONE]) begin
                nxt_abort_done = 1'b0;
            end
            if (avs_writedata[STAT_OVERRUN] && !ovr_evt) begin
                nxt_overrun = 1'b0;
            end
        end
        if (seq_evt.store_done) begin
            nxt_last_index = seq_evt.result_index;
            if (|set_vec) begin
                nxt_snap_result_index = seq_evt.result_index;
            end
            if (|set_vec[15:1]) begin
                nxt_snap_list_bank   = seq_evt.list_bank;
                nxt_snap_result_bank = seq_evt.result_bank;
            end
        end
        if (seq_evt.abort_done) begin
            nxt_snap_list_bank   = seq_evt.list_bank;
            nxt_snap_result_bank = seq_evt.result_bank;
            if (hw_abort) begin
                nxt_snap_result_index = last_index_ff;
            end else begin
                nxt_abort_done = 1'b1;
                if (seq_evt.conv_ongoing) begin
                    nxt_snap_result_index = ctrl_ff[CTRL_STORE_AB] ?
                        seq_evt.result_index : last_index_ff;
                end
            end
            // idle software abort leaves the captured index alone
        end
        if (blank) begin
            nxt_flags             = FLAGS_RST;
            nxt_abort_done        = 1'b0;
            nxt_overrun           = 1'b0;
            nxt_snap_list_bank    = 1'b0;
            nxt_snap_result_bank  = 1'b0;
            nxt_snap_result_index = INDEX_RST;
            nxt_last_index        = INDEX_RST;
        end
        nxt_irq = |(nxt_flags & nxt_en);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_ff             <= FLAGS_RST;
            abort_done_ff        <= 1'b0;
            overrun_ff           <= 1'b0;
            snap_list_bank_ff    <= 1'b0;
            snap_result_bank_ff  <= 1'b0;
            snap_result_index_ff <= INDEX_RST;
            last_index_ff        <= INDEX_RST;
            irq_ff               <= 1'b0;
        end else begin
            flags_ff             <= nxt_flags;
            abort_done_ff        <= nxt_abort_done;
            overrun_ff           <= nxt_overrun;
            snap_list_bank_ff    <= nxt_snap_list_bank;
            snap_result_bank_ff  <= nxt_snap_result_bank;
            snap_result_index_ff <= nxt_snap_result_index;
            last_index_ff        <= nxt_last_index;
            irq_ff               <= nxt_irq;
        end
    end

    assign conv_irq = irq_ff;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_irq_level: assert property (
        conv_irq == |(flags_ff & en_ff))
        else $error("irq does not follow enabled flags");

    a_blank_clear: assert property (
        blank |=> (flags_ff == 16'h0000) && !abort_done_ff)
        else $error("flags not cleared while disabled");

    a_blank_snap: assert property (
        blank |=> (snap_result_index_ff == INDEX_RST) && !overrun_ff
        && !snap_list_bank_ff && !snap_result_bank_ff)
        else $error("snapshot not cleared while disabled");

    a_slot_set: assert property (
        (seq_evt.store_done && seq_evt.flag_select_code != 4'h0 && !blank)
        |=> flags_ff[$past(seq_evt.flag_select_code)])
        else $error("selected done flag not set");

    a_zero_code: assert property (
        (seq_evt.store_done && seq_evt.flag_select_code == 4'h0
         && !seq_evt.command_type_code[1])
        |=> (flags_ff & ~$past(flags_ff)) == 16'h0000)
        else $error("code zero set a flag");

    a_list_end_set: assert property (
        (seq_evt.store_done && seq_evt.command_type_code[1] && !blank)
        |=> flags_ff[0])
        else $error("list-end flag not set");

    a_eol_index: assert property (
        (seq_evt.store_done && seq_evt.command_type_code[1] && !blank
         && !seq_evt.abort_done)
        |=> snap_result_index_ff == $past(seq_evt.result_index))
        else $error("snapshot index not taken at list end");

    a_no_soft_set: assert property (
        (!seq_evt.store_done) |=> (flags_ff & ~$past(flags_ff)) == 16'h0000)
        else $error("flag rose without an event");

    a_w1c_clear: assert property (
        (wr_take && avs_address == IDX_FLAGS && avs_byteenable[0]
         && avs_writedata[1] && !set_vec[1]) |=> !flags_ff[1])
        else $error("write one did not clear the flag");

    a_snap_index: assert property (
        (seq_evt.store_done && seq_evt.flag_select_code != 4'h0 && !blank
         && !seq_evt.abort_done)
        |=> snap_result_index_ff == $past(seq_evt.result_index))
        else $error("snapshot index not taken with flag");

    a_snap_banks: assert property (
        (seq_evt.store_done && seq_evt.flag_select_code != 4'h0 && !blank)
        |=> (snap_list_bank_ff == $past(seq_evt.list_bank))
        && (snap_result_bank_ff == $past(seq_evt.result_bank)))
        else $error("snapshot banks not taken with flag");

    a_overrun_set: assert property (
        (ctrl_ff[CTRL_DBL_BUF] && !blank && |(set_vec & flags_ff))
        |=> overrun_ff)
        else $error("overrun not flagged");

    a_hw_abort: assert property (
        (seq_evt.abort_done && hw_abort && !abort_done_ff)
        |=> !abort_done_ff)
        else $error("hardware abort set abort flag");

    a_hw_index: assert property (
        (seq_evt.abort_done && hw_abort && !blank)
        |=> snap_result_index_ff == $past(last_index_ff))
        else $error("hardware abort index not last stored");

    a_abort_flag: assert property (
        (seq_evt.abort_done && !hw_abort && !blank) |=> abort_done_ff)
        else $error("abort done flag not set");

    a_bus_answer: assert property (
        ((avs_read || avs_write) && bus_st_ff == BUS_IDLE)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

// >>> acir_pkg.sv
// package: register map, field layout and sequencer event carrier
package acir_pkg;

    // word indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL   = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h9;
    localparam logic [3:0] IDX_FLAGS  = 4'hC;
    localparam logic [3:0] IDX_ENABLE = 4'hD;
    localparam logic [3:0] IDX_SNAP   = 4'hE;

    // control register bit positions
    localparam int CTRL_CONV_EN   = 0;
    localparam int CTRL_SOFT_RST  = 1;
    localparam int CTRL_STORE_AB  = 2;
    localparam int CTRL_HALT_WAIT = 3;
    localparam int CTRL_DBL_BUF   = 4;

    // status register bit positions
    localparam int STAT_ABORT_DONE = 7;
    localparam int STAT_OVERRUN    = 6;

    // snapshot field positions
    localparam int SNAP_LIST_BANK   = 15;
    localparam int SNAP_RESULT_BANK = 14;

    // flag and enable bit positions
    localparam int LIST_END_BIT = 0;

    // reset values
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [15:0] FLAGS_RST  = 16'h0000;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [5:0]  INDEX_RST  = 6'h00;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    // events from the conversion sequencer and result store
    typedef struct packed {
        logic       store_done;     // one cycle: command done, result stored
        logic [3:0] flag_select_code;
        logic [1:0] command_type_code;
        logic       first_of_list;  // stored result is top of the list
        logic [5:0] result_index;   // index of stored or aborted conversion
        logic       list_bank;
        logic       result_bank;
        logic       abort_done;     // one cycle: sequence abort executed
        logic       conv_ongoing;   // a conversion was running at abort
        logic       stop_abort;     // abort caused by stop mode entry
        logic       wait_abort;     // abort caused by wait mode entry
    } acir_seq_evt_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } acir_bus_st_t;

endpackage

// >>> acir_seq_model.sv
// sequencer and result store stand-in: replays requested event pulses
`timescale 1ns/1ps
`default_nettype none
module acir_seq_model
    import acir_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire acir_seq_evt_t req,
    output var  acir_seq_evt_t seq_evt
);
    acir_seq_evt_t evt_ff;
    acir_seq_evt_t nxt_evt;

    //////////////////////////////////////////////////////////////////////
    // qualifiers carry nothing between pulses: scramble them each cycle
    always_comb begin
        nxt_evt = req;
        if (!req.store_done && !req.abort_done) begin
            nxt_evt = acir_seq_evt_t'(~evt_ff);
            nxt_evt.store_done = 1'b0;
            nxt_evt.abort_done = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            evt_ff <= '0;
        end else begin
            evt_ff <= nxt_evt;
        end
    end

    assign seq_evt = evt_ff;
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the conversion flag and snapshot block
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin \
    num_errors++; $display("mismatch at %0t: got %h expected %h", \
    $time, act, exp); end end
module tb_top
    import acir_pkg::*;
;
    logic          mclk = 1'b0;
    logic          sys_rst = 1'b1;
    logic [3:0]    avs_address, avs_byteenable;
    logic          avs_read, avs_write, avs_waitrequest;
    logic [31:0]   avs_writedata, avs_readdata, rd;
    acir_seq_evt_t req, seq_evt, e;
    logic          conv_irq, converter_enable, store_on_abort, halt_in_wait;
    int            num_errors, check_count;
    logic [15:0]   en, m, exp_flags, exp_snap;
    logic [5:0]    ix;
    logic [1:0]    bb;
    logic [3:0]    ab_ctrl [4] = '{4'h1, 4'h1, 4'h1, 4'h5};
    logic [5:0]    ab_idx  [4] = '{6'h1C, 6'h1D, 6'h1E, 6'h0B};
    logic          ab_ong  [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic          ab_stp  [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [1:0]    ab_bb   [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    logic [15:0]   ab_snap [4] = '{16'h801A, 16'h401A, 16'h001A, 16'hC00B};
    logic [31:0]   ab_stat [4] = '{32'h80, 32'h80, 32'h00, 32'h80};

    always #5 mclk = ~mclk;

    acir_top DUT (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .seq_evt(seq_evt), .conv_irq(conv_irq),
        .converter_enable(converter_enable),
        .store_on_abort(store_on_abort), .halt_in_wait(halt_in_wait)
    );

    acir_seq_model SEQ (
        .mclk(mclk), .sys_rst(sys_rst), .req(req), .seq_evt(seq_evt)
    );

    //////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        @(posedge mclk);
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic chk_rd(logic [3:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    function automatic acir_seq_evt_t ev(logic s, logic [3:0] c,
        logic [1:0] t, logic [5:0] i, logic [1:0] b, logic o, logic p);
        acir_seq_evt_t v;
        v = '0;
        v.store_done = s;
        v.abort_done = !s;
        v.flag_select_code = c;
        v.command_type_code = t;
        v.result_index = i;
        {v.list_bank, v.result_bank} = b;
        v.conv_ongoing = o;
        v.stop_abort = p;
        return v;
    endfunction

    function automatic logic [15:0] mask(logic [3:0] c, logic [1:0] t);
        return ((c != 4'h0) ? (16'h1 << c) : 16'h0) | {15'h0, t[1]};
    endfunction

    task automatic send(acir_seq_evt_t e);
        req <= e;
        @(posedge mclk);
        req <= '0;
        repeat (3) @(posedge mclk);
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        avs_address = 4'h0;
        avs_byteenable = 4'h3;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        req = '0;
        num_errors = 0;
        check_count = 0;
        void'($urandom(32'hC1FA));
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk_rd(IDX_FLAGS, 32'h0);
        chk_rd(IDX_ENABLE, 32'h0);
        chk_rd(IDX_SNAP, 32'h0);
        wr(4'h5, 32'hFFFF);
        chk_rd(4'h5, 32'h0);
        send(ev(1'b1, 4'h3, 2'h0, 6'h05, 2'h3, 1'b0, 1'b0));
        chk_rd(IDX_FLAGS, 32'h0);
        wr(IDX_CTRL, 32'h1);
        `CHK(converter_enable, 1'b1)
        $display("test reset_blank done");
        for (int c = 1; c < 16; c++) begin
            en = 16'($urandom());
            ix = 6'($urandom());
            bb = 2'($urandom());
            m = 16'h1 << c;
            exp_snap = {bb, 8'h0, ix};
            wr(IDX_ENABLE, {16'h0, en});
            send(ev(1'b1, 4'(c), 2'h0, ix, bb, 1'b0, 1'b0));
            chk_rd(IDX_FLAGS, {16'h0, m});
            `CHK(conv_irq, en[c])
            chk_rd(IDX_SNAP, {16'h0, exp_snap});
            wr(IDX_FLAGS, {16'h0, ~m});
            chk_rd(IDX_FLAGS, {16'h0, m});
            wr(IDX_FLAGS, {16'h0, m});
            chk_rd(IDX_FLAGS, 32'h0);
            `CHK(conv_irq, 1'b0)
        end
        $display("test slot_flags done");
        send(ev(1'b1, 4'h0, 2'h0, 6'h11, 2'h0, 1'b0, 1'b0));
        chk_rd(IDX_FLAGS, 32'h0);
        chk_rd(IDX_SNAP, {16'h0, exp_snap});
        for (int t = 1; t < 4; t++) begin
            ix = 6'($urandom());
            wr(IDX_ENABLE, {31'h0, t == 3});
            send(ev(1'b1, 4'h0, 2'(t), ix, 2'h3, 1'b0, 1'b0));
            if (t > 1) begin
                exp_snap = {exp_snap[15:14], 8'h0, ix};
            end
            chk_rd(IDX_FLAGS, {31'h0, t > 1});
            `CHK(conv_irq, 1'(t == 3))
            chk_rd(IDX_SNAP, {16'h0, exp_snap});
            wr(IDX_FLAGS, 32'h1);
        end
        $display("test list_end done");
        wr(IDX_CTRL, 32'h11);
        send(ev(1'b1, 4'h3, 2'h0, 6'h02, 2'h0, 1'b0, 1'b0));
        chk_rd(IDX_STATUS, 32'h0);
        send(ev(1'b1, 4'h3, 2'h0, 6'h03, 2'h0, 1'b0, 1'b0));
        chk_rd(IDX_STATUS, 32'h40);
        wr(IDX_STATUS, 32'hC0);
        wr(IDX_FLAGS, 32'hFFFF);
        wr(IDX_CTRL, 32'h1);
        send(ev(1'b1, 4'h4, 2'h0, 6'h04, 2'h0, 1'b0, 1'b0));
        chk_rd(IDX_STATUS, 32'h0);
        e = ev(1'b1, 4'h0, 2'h0, 6'h05, 2'h0, 1'b0, 1'b0);
        e.first_of_list = 1'b1;
        send(e);
        chk_rd(IDX_STATUS, 32'h40);
        wr(IDX_STATUS, 32'hC0);
        wr(IDX_FLAGS, 32'hFFFF);
        $display("test overrun done");
        send(ev(1'b1, 4'h2, 2'h0, 6'h1A, 2'h0, 1'b0, 1'b0));
        for (int k = 0; k < 4; k++) begin
            wr(IDX_CTRL, {28'h0, ab_ctrl[k]});
            send(ev(1'b0, 4'h0, 2'h0, ab_idx[k], ab_bb[k], ab_ong[k],
                    ab_stp[k]));
            chk_rd(IDX_SNAP, {16'h0, ab_snap[k]});
            chk_rd(IDX_STATUS, ab_stat[k]);
            wr(IDX_STATUS, 32'hC0);
        end
        `CHK(store_on_abort, 1'b1)
        $display("test abort done");
        wr(IDX_SNAP, 32'hFFFF);
        chk_rd(IDX_SNAP, 32'hC00B);
        wr(IDX_CTRL, 32'h9);
        `CHK(halt_in_wait, 1'b1)
        e = ev(1'b0, 4'h0, 2'h0, 6'h2C, 2'h0, 1'b1, 1'b0);
        e.wait_abort = 1'b1;
        send(e);
        chk_rd(IDX_SNAP, 32'h001A);
        chk_rd(IDX_STATUS, 32'h0);
        wr(IDX_CTRL, 32'h1);
        send(e);
        chk_rd(IDX_STATUS, 32'h80);
        wr(IDX_STATUS, 32'hC0);
        send(ev(1'b1, 4'h5, 2'h0, 6'h07, 2'h0, 1'b0, 1'b0));
        wr(IDX_CTRL, 32'h3);
        chk_rd(IDX_FLAGS, 32'h0);
        chk_rd(IDX_SNAP, 32'h0);
        send(ev(1'b1, 4'h6, 2'h2, 6'h08, 2'h0, 1'b0, 1'b0));
        chk_rd(IDX_FLAGS, 32'h0);
        wr(IDX_CTRL, 32'h1);
        $display("test soft_reset done");
        en = 16'($urandom());
        exp_flags = 16'h0;
        wr(IDX_ENABLE, {16'h0, en});
        for (int r = 0; r < 40; r++) begin
            m = mask(4'($urandom()), 2'($urandom()));
            send(ev(1'b1, 4'(m == 16'h0 ? 0 : $clog2(m & ~16'h1)),
                    {m[0], 1'b0}, 6'($urandom()), 2'h0, 1'b0, 1'b0));
            exp_flags = exp_flags | m;
            chk_rd(IDX_FLAGS, {16'h0, exp_flags});
            `CHK(conv_irq, |(exp_flags & en))
            m = 16'($urandom());
            wr(IDX_FLAGS, {16'h0, m});
            exp_flags = exp_flags & ~m;
            chk_rd(IDX_FLAGS, {16'h0, exp_flags});
        end
        $display("test random done");
        final_report();
    end
endmodule
`default_nettype wire
